// ### design/adcf_pkg.sv
package adcf_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] CTRL_IDX = 6'h00;
    localparam logic [5:0] STAT_IDX = 6'h01;
    localparam logic [5:0] ERR_EN_IDX = 6'h06;
    localparam logic [5:0] INT_EN_IDX = 6'h07;
    localparam logic [5:0] FLOW_ERR_IDX = 6'h08;
    localparam logic [5:0] CONV_EV_IDX = 6'h09;
    localparam logic [5:0] CONV_FLAGS_IDX = 6'h0b;
    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SRST_BIT = 1;
    localparam int CTRL_RSTMODE_BIT = 2;
    localparam int CTRL_LDCONF_BIT = 3;
    localparam int CTRL_ATEND_BIT = 4;
    localparam int CTRL_DBLBUF_BIT = 5;
    localparam int CTRL_SGLCSL_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h7d;
    // flow error fields
    localparam int TRIG_ERR_BIT = 3;
    localparam int RSTAR_ERR_BIT = 2;
    localparam int LDCONF_ERR_BIT = 1;
    localparam logic [7:0] FLOW_W1C_MASK = 8'h06;
    // conversion event fields
    localparam int ABORT_DONE_BIT = 7;
    localparam int OVERRUN_BIT = 6;
    localparam logic [7:0] CONV_EV_W1C_MASK = 8'hc0;
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### design/adcf_flag.sv
`timescale 1ns/10ps
module adcf_flag #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic clr_all,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] w1c,
    // state
    output logic [W-1:0] q
);
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    if (W < 1) begin : g_chk
        $error("adcf_flag: width below one");
    end

    // a set in the same cycle as a one-write wins, so no event is lost
    assign q_next = clr_all ? '0 : ((q_reg & ~w1c) | set);
    assign q = q_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end
endmodule

// ### design/adcf_overrun.sv
`timescale 1ns/10ps
module adcf_overrun #(
    parameter int N = 16
) (
    // flags, bit 0 is end of list
    input wire logic [N-1:0] flags,
    input wire logic [N-1:0] set_req,
    // mode and events
    input wire logic double_mode,
    input wire logic first_store,
    // result
    output logic ovr
);
    logic ovr_double;
    logic ovr_single;

    if (N < 2) begin : g_chk
        $error("adcf_overrun: needs end flag and one conversion flag");
    end

    assign ovr_double = |(flags & set_req);
    // end-of-list flag is never examined in single mode
    assign ovr_single = first_store & (|flags[N-1:1]);
    assign ovr = double_mode ? ovr_double : ovr_single;
endmodule

// ### design/adcf_top.sv
`timescale 1ns/10ps
module adcf_top
    import adcf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sequencer events, one-cycle pulses
    input wire logic restart_ev,
    input wire logic trig_bus_ev,
    input wire logic trig_hw_ev,
    input wire logic seq_abort_req,
    input wire logic abort_exec_ev,
    input wire logic cmd_load_ev,
    input wire logic seq_done_ev,
    input wire logic eol_exec_ev,
    input wire logic first_result_ev,
    input wire logic stop_exit_ev,
    input wire logic [15:0] conv_set_req,
    // sequencer levels
    input wire logic abort_lowpower,
    input wire logic last_cmd_busy,
    input wire logic eol_pending,
    input wire logic first_sample_busy,
    // status to sequencer and system
    output logic conv_halt,
    output logic flag_irq,
    output logic module_enabled
);
    import adcf_pkg::*;

    if (ADDR_W < 8) begin : g_chk
        $error("adcf_top: address width below 8 cannot reach the map");
    end

    // bus slave state
    logic aw_held_reg;
    logic w_held_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [5:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    // software registers
    logic [7:0] ctrl_reg;
    logic soft_rst_reg;
    logic [7:0] err_en_reg;
    logic [7:0] int_en_reg;

    // sequencer tracking
    logic aborted_reg;
    logic restart_busy_reg;
    logic started_reg;
    logic seq_active_reg;
    logic trig_seen_reg;
    logic abort_busy_reg;
    logic abort_defer_reg;
    logic first_restart_reg;
    logic halt_reg;
    logic irq_reg;

    // flag states
    logic [7:0] flow_q;
    logic [7:0] conv_ev_q;
    logic [15:0] conv_flags_q;

    // decode
    logic wr_fire;
    logic [5:0] ridx;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic wr_ctrl;
    logic wr_err_en;
    logic wr_int_en;
    logic wr_flow;
    logic wr_conv_ev;
    logic wr_conv_flags;
    logic wr_known;
    logic rd_known;
    logic [31:0] rd_mux;

    // control fields
    logic enable;
    logic clr_all;
    logic restart_mode;
    logic ld_confirm;
    logic at_end;
    logic double_buf;
    logic single_csl;
    logic live;

    // event logic
    logic trig_any;
    logic te_aborted;
    logic te_loading;
    logic te_unstarted;
    logic te_active;
    logic te_sampling;
    logic te_clash;
    logic trig_err_set;
    logic reach_now;
    logic rstar_set;
    logic ldconf_set;
    logic abort_done_set;
    logic ovr_now;
    logic [7:0] flow_set;
    logic [7:0] flow_w1c;
    logic [7:0] conv_ev_set;
    logic [7:0] conv_ev_w1c;
    logic [15:0] conv_flags_w1c;
    logic [7:0] status_word;

    // register write decode
    assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                    {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign wval = wdata_reg & wmask;
    assign wr_ctrl = wr_fire & (waddr_reg == CTRL_IDX) & wstrb_reg[0];
    assign wr_err_en = wr_fire & (waddr_reg == ERR_EN_IDX) & wstrb_reg[0];
    assign wr_int_en = wr_fire & (waddr_reg == INT_EN_IDX) & wstrb_reg[0];
    assign wr_flow = wr_fire & (waddr_reg == FLOW_ERR_IDX);
    assign wr_conv_ev = wr_fire & (waddr_reg == CONV_EV_IDX);
    assign wr_conv_flags = wr_fire & (waddr_reg == CONV_FLAGS_IDX);
    assign wr_known = (waddr_reg == CTRL_IDX) | (waddr_reg == STAT_IDX)
                    | (waddr_reg == ERR_EN_IDX) | (waddr_reg == INT_EN_IDX)
                    | (waddr_reg == FLOW_ERR_IDX) | (waddr_reg == CONV_EV_IDX)
                    | (waddr_reg == CONV_FLAGS_IDX);

    // control fields
    assign enable = ctrl_reg[CTRL_EN_BIT];
    assign restart_mode = ctrl_reg[CTRL_RSTMODE_BIT];
    assign ld_confirm = ctrl_reg[CTRL_LDCONF_BIT];
    assign at_end = ctrl_reg[CTRL_ATEND_BIT];
    assign double_buf = ctrl_reg[CTRL_DBLBUF_BIT];
    assign single_csl = ctrl_reg[CTRL_SGLCSL_BIT];
    assign clr_all = soft_rst_reg | ~enable;
    // a halted sequencer raises no flag until soft-reset or disable
    assign live = enable & ~soft_rst_reg & ~halt_reg;

    // trigger error causes
    assign trig_any = trig_bus_ev | trig_hw_ev;
    assign te_aborted = restart_mode & aborted_reg & trig_any;
    assign te_loading = restart_mode & restart_busy_reg & trig_any;
    // the host starts the first list with a restart alone; its trigger comes from hardware
    assign te_unstarted = ~restart_mode & ~started_reg & trig_bus_ev;
    assign te_active = seq_active_reg & trig_any;
    assign te_sampling = first_sample_busy & trig_any;
    assign te_clash = ~restart_mode & trig_hw_ev & trig_bus_ev;
    assign trig_err_set = live & (te_aborted | te_loading | te_unstarted
                                  | te_active | te_sampling | te_clash);

    // restart error: only when no end or abort point is near
    assign reach_now = eol_exec_ev | (at_end & eol_pending)
                     | seq_abort_req | abort_busy_reg;
    // a restart while the previous one is still loading raises no restart error
    assign rstar_set = live & restart_ev & trig_seen_reg & ~reach_now
                     & ~restart_busy_reg;
    assign ldconf_set = live & restart_mode & restart_ev & ~ld_confirm
                      & ~abort_busy_reg & ~seq_abort_req
                      & ~first_restart_reg & ~single_csl;

    assign flow_set = {4'h0, trig_err_set, rstar_set, ldconf_set, 1'b0};
    // trigger error has no write path; only soft-reset or disable clears it
    assign flow_w1c = wr_flow ? (wval[7:0] & FLOW_W1C_MASK) : 8'h00;

    assign abort_done_set = live & abort_exec_ev & ~abort_lowpower
                          & ~abort_defer_reg & ~(seq_abort_req & last_cmd_busy & at_end);
    assign conv_ev_set = {abort_done_set, live & ovr_now, 6'h00};
    assign conv_ev_w1c = wr_conv_ev ? (wval[7:0] & CONV_EV_W1C_MASK) : 8'h00;
    assign conv_flags_w1c = wr_conv_flags ? wval[15:0] : 16'h0000;

    adcf_flag #(.W(8)) u_flow (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr_all(clr_all),
        .set(flow_set),
        .w1c(flow_w1c),
        .q(flow_q)
    );

    adcf_flag #(.W(8)) u_conv_ev (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr_all(clr_all),
        .set(conv_ev_set),
        .w1c(conv_ev_w1c),
        .q(conv_ev_q)
    );

    adcf_flag #(.W(16)) u_conv_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr_all(clr_all),
        .set(live ? conv_set_req : 16'h0000),
        .w1c(conv_flags_w1c),
        .q(conv_flags_q)
    );

    adcf_overrun #(.N(16)) u_ovr (
        .flags(conv_flags_q),
        .set_req(conv_set_req),
        .double_mode(double_buf),
        .first_store(first_result_ev),
        .ovr(ovr_now)
    );

    // read decode
    assign ridx = s_axi_araddr[7:2];
    assign status_word = {halt_reg, seq_active_reg, trig_seen_reg, restart_busy_reg,
                          aborted_reg, abort_busy_reg, started_reg, first_restart_reg};
    assign rd_known = (ridx == CTRL_IDX) | (ridx == STAT_IDX)
                    | (ridx == ERR_EN_IDX) | (ridx == INT_EN_IDX)
                    | (ridx == FLOW_ERR_IDX) | (ridx == CONV_EV_IDX)
                    | (ridx == CONV_FLAGS_IDX);
    assign rd_mux = (ridx == CTRL_IDX) ? {24'h0, ctrl_reg} :
                    (ridx == STAT_IDX) ? {24'h0, status_word} :
                    (ridx == ERR_EN_IDX) ? {24'h0, err_en_reg} :
                    (ridx == INT_EN_IDX) ? {24'h0, int_en_reg} :
                    (ridx == FLOW_ERR_IDX) ? {24'h0, flow_q} :
                    (ridx == CONV_EV_IDX) ? {24'h0, conv_ev_q} :
                    (ridx == CONV_FLAGS_IDX) ? {16'h0, conv_flags_q} : 32'h0;

    // write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b0;
            waddr_reg <= 6'h00;
        end else if (s_axi_awvalid & awready_reg) begin
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
            waddr_reg <= s_axi_awaddr[7:2];
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end else if (~aw_held_reg & ~bvalid_reg) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid & wready_reg) begin
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end else if (~w_held_reg & ~bvalid_reg) begin
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid & arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg & s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end else if (~rvalid_reg) begin
            arready_reg <= 1'b1;
        end
    end

    // software registers; soft-reset is a one-cycle pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= CTRL_RESET;
            soft_rst_reg <= 1'b0;
            err_en_reg <= EN_RESET;
            int_en_reg <= EN_RESET;
        end else begin
            soft_rst_reg <= wr_ctrl & wval[CTRL_SRST_BIT];
            if (wr_ctrl) begin
                ctrl_reg <= wval[7:0] & CTRL_WMASK;
            end
            if (wr_err_en) begin
                err_en_reg <= wval[7:0];
            end
            if (wr_int_en) begin
                int_en_reg <= wval[7:0];
            end
        end
    end

    // sequencer tracking, cleared with the flags
    always_ff @(posedge aclk) begin
        if (!aresetn || clr_all) begin
            aborted_reg <= 1'b0;
            restart_busy_reg <= 1'b0;
            started_reg <= 1'b0;
            seq_active_reg <= 1'b0;
            trig_seen_reg <= 1'b0;
            abort_busy_reg <= 1'b0;
            abort_defer_reg <= 1'b0;
        end else if (live) begin
            if (abort_exec_ev) begin
                aborted_reg <= 1'b1;
            end else if (restart_ev) begin
                aborted_reg <= 1'b0;
            end
            if (restart_ev) begin
                restart_busy_reg <= 1'b1;
            end else if (cmd_load_ev) begin
                restart_busy_reg <= 1'b0;
            end
            if (restart_ev) begin
                started_reg <= 1'b1;
            end
            if (trig_any) begin
                seq_active_reg <= 1'b1;
            end else if (seq_done_ev | abort_exec_ev) begin
                seq_active_reg <= 1'b0;
            end
            if (trig_any) begin
                trig_seen_reg <= 1'b1;
            end else if (reach_now) begin
                trig_seen_reg <= 1'b0;
            end
            if (seq_abort_req) begin
                abort_busy_reg <= 1'b1;
            end else if (abort_exec_ev) begin
                abort_busy_reg <= 1'b0;
            end
            // an abort deferred to the list end is not reported as done
            if (seq_abort_req & last_cmd_busy & at_end) begin
                abort_defer_reg <= 1'b1;
            end else if (abort_exec_ev) begin
                abort_defer_reg <= 1'b0;
            end
        end
    end

    // first restart after enable, stop exit or soft-reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_restart_reg <= 1'b1;
        end else if (clr_all | stop_exit_ev) begin
            first_restart_reg <= 1'b1;
        end else if (restart_ev) begin
            first_restart_reg <= 1'b0;
        end
    end

    // outputs; restart and load errors do not halt the sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            halt_reg <= flow_q[TRIG_ERR_BIT] | trig_err_set;
            irq_reg <= |(flow_q & err_en_reg) | |(conv_ev_q & int_en_reg);
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign conv_halt = halt_reg;
    assign flag_irq = irq_reg;
    assign module_enabled = ctrl_reg[CTRL_EN_BIT];
endmodule

// ### bench/adcf_top_sva.sv
`timescale 1ns/10ps
module adcf_top_sva
    import adcf_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    // events and status
    input wire logic trig_bus_ev,
    input wire logic trig_hw_ev,
    input wire logic conv_halt,
    input wire logic flag_irq,
    input wire logic module_enabled
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // only a register write (soft-reset or disable) may lift the halt
    property p_halt_sticky;
        $fell(conv_halt) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
    endproperty
    a_halt_sticky: assert property (p_halt_sticky) else $error("halt dropped");
    property p_halt_cause;
        $rose(conv_halt) |-> $past(trig_bus_ev || trig_hw_ev);
    endproperty
    a_halt_cause: assert property (p_halt_cause) else $error("halt no trigger");
    property p_disabled;
        !module_enabled [*4] |-> !conv_halt && !flag_irq;
    endproperty
    a_disabled: assert property (p_disabled) else $error("flags while disabled");
    property p_en_write;
        module_enabled != $past(module_enabled) |-> s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_en_write: assert property (p_en_write) else $error("enable moved alone");
    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("bresp not held");
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_slverr;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > CONV_FLAGS_IDX
            |=> s_axi_rresp == RESP_SLVERR;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped read okay");
endmodule

bind adcf_top adcf_top_sva #(.ADDR_W(ADDR_W)) u_sva (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .trig_bus_ev, .trig_hw_ev,
    .conv_halt, .flag_irq, .module_enabled);

// ### bench/test_adcf_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_adcf_top
    import adcf_pkg::*;
;
    localparam logic [9:0] EV_RST = 10'h001, EV_BUS = 10'h002, EV_HW = 10'h004;
    localparam logic [9:0] EV_SQA = 10'h008, EV_AEX = 10'h010, EV_LOAD = 10'h020;
    localparam logic [9:0] EV_DONE = 10'h040, EV_EOL = 10'h080, EV_FRST = 10'h100;
    localparam logic [9:0] EV_STOP = 10'h200;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_v;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic conv_halt, flag_irq, module_enabled;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [9:0] evs = 0;
    logic [15:0] cset = 0, seed = 16'h004d;
    logic lowpwr = 0, lastbusy = 0, eolpend = 0, smpbusy = 0;
    int failures = 0, n_checks = 0;
    logic [9:0] tseq [5][5] = '{
        '{EV_RST, EV_LOAD, EV_HW, EV_BUS, 10'h0},
        '{EV_RST, EV_LOAD, EV_HW | EV_BUS, 10'h0, 10'h0},
        '{EV_RST, EV_LOAD, EV_HW, EV_EOL | EV_DONE, EV_RST},
        '{EV_RST, EV_LOAD, EV_HW, EV_RST, 10'h0},
        '{EV_RST, EV_HW, EV_RST, 10'h0, 10'h0}};
    logic [3:0] texp [5] = '{4'h8, 4'h8, 4'h0, 4'h4, 4'h0};

    adcf_top dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .restart_ev(evs[0]),
        .trig_bus_ev(evs[1]), .trig_hw_ev(evs[2]), .seq_abort_req(evs[3]),
        .abort_exec_ev(evs[4]), .cmd_load_ev(evs[5]), .seq_done_ev(evs[6]),
        .eol_exec_ev(evs[7]), .first_result_ev(evs[8]), .stop_exit_ev(evs[9]),
        .conv_set_req(cset), .abort_lowpower(lowpwr), .last_cmd_busy(lastbusy),
        .eol_pending(eolpend), .first_sample_busy(smpbusy), .conv_halt, .flag_irq,
        .module_enabled);

    always #2.5 aclk = ~aclk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // enable registers keep the whole written byte
    function automatic logic [31:0] rb(input logic [15:0] d);
        return {24'h0, d[7:0]};
    endfunction

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (!s_axi_awready);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (!s_axi_wready);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd_v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [5:0] idx, input logic [31:0] e);
        rd(idx);
        `CHK(nm, e, rd_v)
    endtask

    // one-cycle event pulse; events are sampled every cycle, so a held level would count again
    task automatic pulse(input logic [9:0] m, input logic [15:0] c = 16'h0000);
        @(posedge aclk);
        evs <= m;
        cset <= c;
        @(posedge aclk);
        evs <= 10'h000;
        cset <= 16'h0000;
    endtask

    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("ctrl", CTRL_IDX, 32'h0);
        rchk("flow", FLOW_ERR_IDX, 32'h0);
        rchk("conv_ev", CONV_EV_IDX, 32'h0);
        rd(6'h3f);
        `CHK("rd resp", RESP_SLVERR, resp)
        `CHK("rd data", 32'h0, rd_v)
        wr(6'h3f, 32'hff);
        `CHK("wr resp", RESP_SLVERR, resp)
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wr(i[0] ? INT_EN_IDX : ERR_EN_IDX, {16'h0, seed});
            rchk("enable", i[0] ? INT_EN_IDX : ERR_EN_IDX, rb(seed));
        end
        wr(ERR_EN_IDX, 32'h0);
        wr(INT_EN_IDX, 32'h0);
        $display("test registers done");
        wr(CTRL_IDX, 32'h01);
        `CHK("enabled", 1'b1, module_enabled)
        for (int r = 0; r < 5; r++) begin
            for (int s = 0; s < 5; s++) pulse(tseq[r][s]);
            rchk("flow", FLOW_ERR_IDX, {28'h0, texp[r]});
            `CHK("halt", texp[r][3], conv_halt)
            wr(CTRL_IDX, 32'h03);
        end
        pulse(EV_BUS);
        wr(FLOW_ERR_IDX, 32'hff);
        rchk("flow", FLOW_ERR_IDX, 32'h8);
        wr(CTRL_IDX, 32'h03);
        rchk("flow", FLOW_ERR_IDX, 32'h0);
        `CHK("halt", 1'b0, conv_halt)
        wr(CTRL_IDX, 32'h11);
        for (int s = 0; s < 3; s++) pulse(tseq[3][s]);
        eolpend <= 1'b1;
        pulse(EV_RST);
        eolpend <= 1'b0;
        rchk("flow", FLOW_ERR_IDX, 32'h0);
        $display("test trigger mode done");
        wr(CTRL_IDX, 32'h07);
        pulse(EV_RST);
        pulse(EV_LOAD);
        rchk("flow", FLOW_ERR_IDX, 32'h0);
        pulse(EV_RST);
        pulse(EV_LOAD);
        rchk("flow", FLOW_ERR_IDX, 32'h2);
        `CHK("halt", 1'b0, conv_halt)
        wr(FLOW_ERR_IDX, 32'h0);
        rchk("flow", FLOW_ERR_IDX, 32'h2);
        wr(FLOW_ERR_IDX, 32'h2);
        rchk("flow", FLOW_ERR_IDX, 32'h0);
        pulse(EV_RST | EV_SQA);
        pulse(EV_AEX);
        rchk("flow", FLOW_ERR_IDX, 32'h0);
        rchk("conv_ev", CONV_EV_IDX, 32'h80);
        wr(INT_EN_IDX, 32'h80);
        rchk("int_en", INT_EN_IDX, 32'h80);
        `CHK("irq", 1'b1, flag_irq)
        wr(CONV_EV_IDX, 32'h80);
        rchk("conv_ev", CONV_EV_IDX, 32'h0);
        `CHK("irq", 1'b0, flag_irq)
        lowpwr <= 1'b1;
        pulse(EV_SQA);
        pulse(EV_AEX);
        lowpwr <= 1'b0;
        rchk("conv_ev", CONV_EV_IDX, 32'h0);
        wr(CTRL_IDX, 32'h15);
        lastbusy <= 1'b1;
        pulse(EV_SQA);
        lastbusy <= 1'b0;
        pulse(EV_AEX);
        rchk("conv_ev", CONV_EV_IDX, 32'h0);
        pulse(EV_LOAD);
        pulse(EV_BUS);
        rchk("flow", FLOW_ERR_IDX, 32'h8);
        wr(CTRL_IDX, 32'h07);
        pulse(EV_RST);
        pulse(EV_BUS);
        rchk("flow", FLOW_ERR_IDX, 32'h8);
        wr(CTRL_IDX, 32'h07);
        smpbusy <= 1'b1;
        pulse(EV_BUS);
        smpbusy <= 1'b0;
        rchk("flow", FLOW_ERR_IDX, 32'h8);
        wr(CTRL_IDX, 32'h47);
        for (int i = 0; i < 4; i++) pulse(i[0] ? EV_LOAD : EV_RST);
        rchk("flow", FLOW_ERR_IDX, 32'h0);
        wr(CTRL_IDX, 32'h07);
        for (int i = 0; i < 5; i++) pulse(i == 2 ? EV_STOP : i[0] ? EV_LOAD : EV_RST);
        rchk("flow", FLOW_ERR_IDX, 32'h0);
        $display("test restart mode done");
        wr(CTRL_IDX, 32'h23);
        pulse(10'h0, 16'h0001);
        rchk("flags", CONV_FLAGS_IDX, 32'h1);
        pulse(10'h0, 16'h0001);
        rchk("conv_ev", CONV_EV_IDX, 32'h40);
        wr(CTRL_IDX, 32'h03);
        rchk("conv_ev", CONV_EV_IDX, 32'h0);
        pulse(10'h0, 16'h0001);
        pulse(10'h0, 16'h0001);
        pulse(EV_FRST);
        rchk("conv_ev", CONV_EV_IDX, 32'h0);
        seed = lfsr(seed);
        pulse(10'h0, 16'h0001 << (1 + seed % 15));
        pulse(EV_FRST);
        rchk("conv_ev", CONV_EV_IDX, 32'h40);
        wr(CTRL_IDX, 32'h00);
        rchk("conv_ev", CONV_EV_IDX, 32'h0);
        rchk("flags", CONV_FLAGS_IDX, 32'h0);
        $display("test overrun done");
        wrap_up();
    end
endmodule
